// File: hdl/mfc_detector.sv
// Slope detector with duration filter, any-motion or no-motion.
// Assumes sample_in pulses once per 20 ms sample.
`include "mfc_params.svh"
module mfc_detector (
  // Clock and reset
  input  wire logic                 core_clk_in,
  input  wire logic                 reset_in,
  // Samples and settings
  input  wire logic                 sample_in,
  input  wire mfc_pkg::mfc_axes_t   axes_in,
  input  wire mfc_pkg::mfc_det_cfg_t cfg_in,
  input  wire mfc_pkg::mfc_mode_t   mode_in,
  // Event level
  output logic                      event_out
);
  import mfc_pkg::*;
  mfc_axes_t   prev_r;
  logic        have_prev_r;
  logic [12:0] cnt_r;
  logic [12:0] cnt_nxt;
  logic [2:0]  hi;
  logic [2:0]  lo;
  logic        cond;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_slope
      logic [16:0] diff;
      logic [16:0] mag;
      assign diff = {axes_in.axis[gi][15], axes_in.axis[gi]} - {prev_r.axis[gi][15], prev_r.axis[gi]};
      assign mag  = diff[16] ? 17'(-diff) : diff;
      assign hi[gi] = cfg_in.en[gi] && ((mag >> `MFC_SLOPE_SHIFT) > {6'h00, cfg_in.thr}); // RULE3 RULE7
      assign lo[gi] = !cfg_in.en[gi] || ((mag >> `MFC_SLOPE_SHIFT) < {6'h00, cfg_in.thr}); // RULE7
    end
  endgenerate
  // No enabled axis means no-motion never fires
  assign cond = (mode_in == MFC_ANY) ? |hi : (|cfg_in.en && &lo); // RULE16
  // Saturating 13-bit count spans about 163 s of samples
  assign cnt_nxt = (cnt_r == 13'h1FFF) ? cnt_r : cnt_r + 13'h1; // RULE6
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      prev_r      <= '0;
      have_prev_r <= 1'b0;
    end else if (sample_in) begin
      prev_r      <= axes_in;
      have_prev_r <= 1'b1;
    end
  end
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      cnt_r     <= 13'h0;
      event_out <= 1'b0;
    end else if (sample_in && have_prev_r) begin
      cnt_r     <= cond ? cnt_nxt : 13'h0; // RULE5
      event_out <= cond && (cnt_nxt >= cfg_in.dur); // RULE5
    end
  end
  // ***************************
  // Checks
  // ***************************
  AST_DET_DROP: assert property (@(posedge core_clk_in) disable iff (reset_in) // RULE5
    (sample_in && have_prev_r && !cond) |=> !event_out && (cnt_r == 13'h0))
    else $error("event stayed after condition broke");
  AST_DET_DUR: assert property (@(posedge core_clk_in) disable iff (reset_in) // RULE16
    $rose(event_out) |-> (cnt_r >= $past(cfg_in.dur)) && $past(cond))
    else $error("event rose before duration elapsed");
endmodule

// File: hdl/mfc_remap.sv
// Axis routing and sign inversion of one acceleration sample.
// Assumes the routing word is stable while a sample is taken.
`include "mfc_params.svh"
module mfc_remap (
  // Sample and routing
  input  wire mfc_pkg::mfc_axes_t axes_in,
  input  wire logic [8:0]         route_in,
  // Routed sample
  output mfc_pkg::mfc_axes_t      axes_out
);
  import mfc_pkg::*;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_axis
      logic [1:0]  sel;
      logic [1:0]  src;
      logic [15:0] val;
      assign sel = route_in[3*gi +: 2];
      // Reserved code keeps the axis on itself
      assign src = (sel == 2'h3) ? 2'(gi) : sel; // RULE8 RULE9 RULE10
      assign val = axes_in.axis[src];
      // Negating full scale wraps; accepted as a one-code limit
      assign axes_out.axis[gi] = route_in[3*gi+2] ? 16'(-val) : val; // RULE11 RULE12 RULE13
    end
  endgenerate
endmodule

// File: hdl/mfc_top.sv
// Feature configuration store behind the byte port register,
// with axis routing, two motion detectors and pin one mapping.
// Assumes host strobes are synchronous, one cycle each.
`include "mfc_params.svh"
module mfc_top #(
  parameter int SAMPLE_CYCLES = `MFC_SAMPLE_CYC
) (
  // Clock and reset
  input  wire logic               core_clk_in,
  input  wire logic               reset_in,
  // Register access
  input  wire logic [7:0]         reg_addr_in,
  input  wire logic               reg_wr_in,
  input  wire logic               reg_rd_in,
  input  wire logic [7:0]         reg_wdata_in,
  output logic [7:0]              reg_rdata_out,
  // Acceleration sample
  input  wire mfc_pkg::mfc_axes_t acc_in,
  // Results
  output mfc_pkg::mfc_axes_t      mapped_acc_out,
  output logic                    any_motion_out,
  output logic                    no_motion_out,
  output logic                    int1_out
);
  import mfc_pkg::*;

  // ***************************
  // Feature byte layout
  // ***************************
  function automatic logic [7:0] rst_byte(input logic [3:0] i);
    logic [15:0] w;
    w = 16'h0000;
    case (i[3:1])
      3'h0: w = `MFC_W1_RST;
      3'h1: w = `MFC_W2_RST;
      3'h2: w = `MFC_W1_RST;
      3'h3: w = `MFC_W2_RST;
      3'h5: w = `MFC_REMAP_RST;
      default: w = 16'h0000;
    endcase
    return i[0] ? w[15:8] : w[7:0];
  endfunction

  function automatic logic [7:0] wr_mask(input logic [3:0] i);
    logic [15:0] w;
    w = 16'h0000;
    case (i[3:1])
      3'h0: w = `MFC_W1_MASK;
      3'h1: w = 16'hFFFF;
      3'h2: w = `MFC_W1_MASK;
      3'h3: w = 16'hFFFF;
      3'h5: w = `MFC_REMAP_MASK;
      default: w = 16'h0000;
    endcase
    return i[0] ? w[15:8] : w[7:0];
  endfunction

  // ***************************
  // Declarations
  // ***************************
  logic [7:0]   feat_r [0:11];
  logic [3:0]   ptr_r;
  logic [3:0]   ptr_nxt;
  logic [7:0]   map1_r;
  logic         port_hit;
  logic         port_wr;
  logic         port_acc;
  logic         other_acc;
  logic [7:0]   rd_byte;
  logic [7:0]   rdata_nxt;
  logic [15:0]  am_w1;
  logic [15:0]  am_w2;
  logic [15:0]  nm_w1;
  logic [15:0]  nm_w2;
  logic [15:0]  remap_w;
  logic [19:0]  tick_cnt_r;
  logic         tick;
  logic         sample_vld_r;
  mfc_axes_t    routed;
  mfc_axes_t    mapped_r;
  mfc_det_cfg_t am_cfg;
  mfc_det_cfg_t nm_cfg;
  logic         am_evt;
  logic         nm_evt;

  // ***************************
  // Port decode
  // ***************************
  assign port_hit  = (reg_addr_in == `MFC_PORT_ADDR);
  assign port_wr   = port_hit && reg_wr_in;
  assign port_acc  = port_hit && (reg_wr_in || reg_rd_in);
  assign other_acc = !port_hit && (reg_wr_in || reg_rd_in);
  assign rd_byte   = feat_r[ptr_r];

  // Pointer wraps so a burst never leaves the feature area
  assign ptr_nxt = (ptr_r == `MFC_FEAT_LAST) ? 4'h0 : ptr_r + 4'h1;

  // Touching any other register rewinds the burst
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      ptr_r <= 4'h0;
    end else if (port_acc) begin
      ptr_r <= ptr_nxt; // RULE15
    end else if (other_acc) begin
      ptr_r <= 4'h0;
    end
  end

  // ***************************
  // Feature storage
  // ***************************
  genvar gi;
  generate
    for (gi = 0; gi < 12; gi++) begin : g_byte
      always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
          feat_r[gi] <= rst_byte(4'(gi)); // RULE2 RULE4
        end else if (port_wr && (ptr_r == 4'(gi))) begin
          // Reserved bits stay zero whatever is written
          feat_r[gi] <= reg_wdata_in & wr_mask(4'(gi)); // RULE1
        end
      end
    end
  endgenerate

  assign am_w1   = {feat_r[`MFC_AM_OFS + 4'h1], feat_r[`MFC_AM_OFS]};
  assign am_w2   = {feat_r[`MFC_AM_OFS + 4'h3], feat_r[`MFC_AM_OFS + 4'h2]};
  assign nm_w1   = {feat_r[`MFC_NM_OFS + 4'h1], feat_r[`MFC_NM_OFS]};
  assign nm_w2   = {feat_r[`MFC_NM_OFS + 4'h3], feat_r[`MFC_NM_OFS + 4'h2]};
  assign remap_w = {feat_r[`MFC_REMAP_OFS + 4'h1], feat_r[`MFC_REMAP_OFS]};

  assign am_cfg.thr = am_w1[`MFC_THR_MSB:0]; // RULE3
  assign am_cfg.dur = am_w2[`MFC_DUR_MSB:0]; // RULE6
  assign am_cfg.en  = am_w2[15:`MFC_EN_LSB]; // RULE7
  assign nm_cfg.thr = nm_w1[`MFC_THR_MSB:0]; // RULE4
  assign nm_cfg.dur = nm_w2[`MFC_DUR_MSB:0]; // RULE6
  assign nm_cfg.en  = nm_w2[15:`MFC_EN_LSB]; // RULE7

  // ***************************
  // Pin one mapping register
  // ***************************
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      map1_r <= `MFC_MAP1_RST;
    end else if (reg_wr_in && (reg_addr_in == `MFC_MAP1_ADDR)) begin
      map1_r <= reg_wdata_in & `MFC_MAP1_MASK;
    end
  end

  // ***************************
  // Read data
  // ***************************
  always_comb begin
    rdata_nxt = reg_rdata_out;
    if (reg_rd_in) begin
      if (port_hit) begin
        rdata_nxt = rd_byte; // RULE15
      end else if (reg_addr_in == `MFC_MAP1_ADDR) begin
        rdata_nxt = map1_r;
      end else begin
        rdata_nxt = 8'h00;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      reg_rdata_out <= `MFC_PORT_RST; // RULE1
    end else begin
      reg_rdata_out <= rdata_nxt;
    end
  end

  // ***************************
  // Sample timing
  // ***************************
  // The 50 Hz rate is made here so duration counts are exact
  assign tick = (tick_cnt_r == 20'(SAMPLE_CYCLES - 1));

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      tick_cnt_r <= 20'h00000;
    end else if (tick) begin
      tick_cnt_r <= 20'h00000;
    end else begin
      tick_cnt_r <= tick_cnt_r + 20'h00001;
    end
  end

  // ***************************
  // Axis routing
  // ***************************
  mfc_remap u_remap (
    .axes_in  (acc_in),
    .route_in (remap_w[8:0]),
    .axes_out (routed)
  );

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      mapped_r     <= '0;
      sample_vld_r <= 1'b0;
    end else begin
      sample_vld_r <= tick; // RULE5
      if (tick) begin
        mapped_r <= routed; // RULE8 RULE9 RULE10
      end
    end
  end

  assign mapped_acc_out = mapped_r;

  // ***************************
  // Detectors
  // ***************************
  mfc_detector u_any (
    .core_clk_in (core_clk_in),
    .reset_in    (reset_in),
    .sample_in   (sample_vld_r),
    .axes_in     (mapped_r),
    .cfg_in      (am_cfg),
    .mode_in     (MFC_ANY),
    .event_out   (am_evt)
  );

  mfc_detector u_no (
    .core_clk_in (core_clk_in),
    .reset_in    (reset_in),
    .sample_in   (sample_vld_r),
    .axes_in     (mapped_r),
    .cfg_in      (nm_cfg),
    .mode_in     (MFC_NO),
    .event_out   (nm_evt)
  );

  assign any_motion_out = am_evt;
  assign no_motion_out  = nm_evt;

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      int1_out <= 1'b0;
    end else begin
      int1_out <= (map1_r[`MFC_MAP1_ANY] && am_evt) || (map1_r[`MFC_MAP1_NO] && nm_evt); // RULE14
    end
  end

  // ***************************
  // Checks
  // ***************************
  sequence seq_port_write;
    port_wr;
  endsequence

  sequence seq_port_read;
    port_hit && reg_rd_in && !reg_wr_in;
  endsequence

  AST_PORT_RST: assert property (@(posedge core_clk_in) // RULE1
    reset_in |=> (reg_rdata_out == 8'h00) && (ptr_r == 4'h0))
    else $error("port not cleared by reset");

  AST_PTR_STEP: assert property (@(posedge core_clk_in) disable iff (reset_in) // RULE15
    (port_acc && (ptr_r != `MFC_FEAT_LAST)) |=> (ptr_r == $past(ptr_r) + 4'h1))
    else $error("pointer did not step");

  AST_RD_BURST: assert property (@(posedge core_clk_in) disable iff (reset_in) // RULE15
    seq_port_read ##1 seq_port_read |=> (reg_rdata_out == feat_r[$past(ptr_r) - 4'h1 + 4'h1]))
    else $error("burst read returned wrong byte");

  AST_WR_STORE: assert property (@(posedge core_clk_in) disable iff (reset_in) // RULE2
    seq_port_write |=> (feat_r[$past(ptr_r)] == ($past(reg_wdata_in) & wr_mask($past(ptr_r)))))
    else $error("port write not stored");

  AST_RSVD_ZERO: assert property (@(posedge core_clk_in) disable iff (reset_in) // RULE4
    (feat_r[`MFC_RSVD_OFS] == 8'h00) && (feat_r[`MFC_RSVD_OFS + 4'h1] == 8'h00) && (nm_w1[15:11] == 5'h00))
    else $error("reserved feature bits not zero");

  AST_ROUTE_X3: assert property (@(posedge core_clk_in) disable iff (reset_in) // RULE8
    (remap_w[1:0] == 2'h3 && !remap_w[2]) |-> (routed.axis[0] == acc_in.axis[0]))
    else $error("reserved x route not on x");

  AST_INV_Y: assert property (@(posedge core_clk_in) disable iff (reset_in) // RULE12
    (remap_w[4:3] == 2'h1 && remap_w[5]) |-> (routed.axis[1] == 16'(-acc_in.axis[1])))
    else $error("y inversion wrong");

  AST_TICK: assert property (@(posedge core_clk_in) disable iff (reset_in) // RULE5
    tick |=> sample_vld_r ##1 !sample_vld_r)
    else $error("sample strobe not one cycle");

  AST_INT1: assert property (@(posedge core_clk_in) disable iff (reset_in) // RULE14
    (am_evt && map1_r[`MFC_MAP1_ANY]) |=> int1_out)
    else $error("any-motion not on pin one");

  AST_INT1_OFF: assert property (@(posedge core_clk_in) disable iff (reset_in) // RULE14
    (map1_r[7:5] == 3'h0) [*2] |-> !int1_out)
    else $error("pin one high while unmapped");
endmodule

// File: include/mfc_params.svh
// Constants of the motion feature configuration port.
// Assumes a 25 MHz core clock and byte-wide register access.
//
// What this block does
// RULE1: A byte-wide read/write port register at 0x5E, reset to zero, carries all feature data.
// RULE2: Any-motion words sit at feature bytes 0x00 and 0x02 and reset to 0x00AA and 0x0005.
// RULE3: The any-motion threshold is bits 10:0 of its first word, 0 to 1 g, default 0xAA (about 83 mg).
// RULE4: No-motion words sit at bytes 0x04 and 0x06, threshold default 0xAA with the same range.
// RULE5: A detector fires only after its condition holds for duration consecutive 20 ms samples, default 5.
// RULE6: The 13-bit duration spans 0 to about 163 s, and 5 samples make 100 ms.
// RULE7: Bits 13, 14 and 15 of each second word enable the x, y and z axes, all off at reset.
// RULE8: The x route field picks x, y or z for codes 0, 1, 2, code 3 picks x, default 0.
// RULE9: The y route field uses the same codes, default 1, code 3 picks y.
// RULE10: The z route field in bits 7:6 uses the same codes, default 2, code 3 picks z.
// RULE11: Remap bit 2 inverts the mapped x axis when set, default clear.
// RULE12: Remap bit 5 inverts the mapped y axis when set, default clear.
// RULE13: Remap bit 8 inverts the mapped z axis when set, default clear.
// RULE14: Interrupt pin one carries any-motion when map bit 5 is set and no-motion when bit 6 is set.
// RULE15: Each access to the port steps to the next feature byte so words move in one burst.
// RULE16: Any-motion holds when an enabled axis slope exceeds threshold, no-motion when all stay below; no-motion also needs an enabled axis.
`ifndef MFC_PARAMS_SVH
`define MFC_PARAMS_SVH
// ***************************
// Register addresses
// ***************************
`define MFC_PORT_ADDR   8'h5E
`define MFC_MAP1_ADDR   8'h56
`define MFC_MAP1_RST    8'h00
`define MFC_PORT_RST    8'h00
// ***************************
// Feature area byte offsets
// ***************************
`define MFC_AM_OFS      4'h0
`define MFC_NM_OFS      4'h4
`define MFC_RSVD_OFS    4'h8
`define MFC_REMAP_OFS   4'hA
`define MFC_FEAT_LAST   4'hB
// ***************************
// Field positions and resets
// ***************************
`define MFC_THR_MSB     10
`define MFC_DUR_MSB     12
`define MFC_EN_LSB      13
`define MFC_MAP1_ANY    5
`define MFC_MAP1_NO     6
`define MFC_MAP1_MASK   8'hE0
`define MFC_W1_RST      16'h00AA
`define MFC_W2_RST      16'h0005
`define MFC_W1_MASK     16'h07FF
`define MFC_REMAP_RST   16'h0088
`define MFC_REMAP_MASK  16'h01FF
`define MFC_SLOPE_SHIFT 4
// ***************************
// Timing
// ***************************
`define MFC_SAMPLE_NS   20000000
`define MFC_CLK_NS      40
`define MFC_SAMPLE_CYC  (`MFC_SAMPLE_NS / `MFC_CLK_NS)
`endif

// File: include/mfc_pkg.sv
// Types shared by the motion feature configuration port.
// Assumes nothing beyond a SystemVerilog compiler.
package mfc_pkg;
  typedef struct packed {
    logic [2:0][15:0] axis;
  } mfc_axes_t;
  typedef struct packed {
    logic [2:0]  en;
    logic [12:0] dur;
    logic [10:0] thr;
  } mfc_det_cfg_t;
  typedef enum logic {
    MFC_ANY = 1'b0,
    MFC_NO  = 1'b1
  } mfc_mode_t;
endpackage

// File: tb/mfc_host_model.sv
// Host controller model driving the byte-wide register port.
// Assumes it is called at a falling clock edge; one byte moves per cycle.
module mfc_host_model (
  // Clock
  input  wire logic       core_clk_in,
  // Register access
  output logic [7:0]      reg_addr_out,
  output logic            reg_wr_out,
  output logic            reg_rd_out,
  output logic [7:0]      reg_wdata_out,
  input  wire logic [7:0] reg_rdata_in
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    reg_addr_out  = 8'h00;
    reg_wr_out    = 1'b0;
    reg_rd_out    = 1'b0;
    reg_wdata_out = 8'h00;
  end

  // Strobes stay up on return so that calls in a row form a burst
  task automatic xfer(input logic [7:0] addr, input logic wr, input logic [7:0] wdata, output logic [7:0] rdata);
    reg_addr_out  = addr;
    reg_wr_out    = wr;
    reg_rd_out    = !wr;
    reg_wdata_out = wr ? wdata : ~reg_wdata_out;
    @(negedge core_clk_in);
    rdata = reg_rdata_in;
  endtask

  // Data line toggles once released, so a stale byte is never mistaken for a write
  task automatic idle();
    reg_wr_out    = 1'b0;
    reg_rd_out    = 1'b0;
    reg_wdata_out = ~reg_wdata_out;
    @(negedge core_clk_in);
  endtask
endmodule

// File: tb/motion_feature_config_port_test.sv
// Self-checking bench of the feature configuration port.
// Assumes the host model and the bench change inputs at falling edges only.
`include "mfc_params.svh"
module motion_feature_config_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  import mfc_pkg::*;

  // ***************************
  // Signals and tables
  // ***************************
  // Short sample period keeps the detector runs brief
  localparam int SC = 8;
  typedef struct packed {
    logic [7:0] wdata;
    logic [7:0] after;
    logic [7:0] rst;
  } mfc_row_t;

  logic       core_clk;
  logic       reset;
  logic [7:0] reg_addr;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  mfc_axes_t  acc;
  mfc_axes_t  mapped;
  logic       any_m;
  logic       no_m;
  logic       int1;
  logic [7:0] rb;
  int         bad_count    = 0;
  int         total_checks = 0;

  mfc_row_t rows [12] = '{'{8'hC3, 8'hC3, 8'hAA}, '{8'hC3, 8'h03, 8'h00}, '{8'hC3, 8'hC3, 8'h05},
                         '{8'hC3, 8'hC3, 8'h00}, '{8'hC3, 8'hC3, 8'hAA}, '{8'hC3, 8'h03, 8'h00},
                         '{8'hC3, 8'hC3, 8'h05}, '{8'hC3, 8'hC3, 8'h00}, '{8'hC3, 8'h00, 8'h00},
                         '{8'hC3, 8'h00, 8'h00}, '{8'hC3, 8'hC3, 8'h88}, '{8'hC3, 8'h01, 8'h00}};
  logic [8:0] remaps [4] = '{9'h088, 9'h011, 9'h0DB, 9'h1AC};

  mfc_top #(.SAMPLE_CYCLES(SC)) u_dut (
    .core_clk_in    (core_clk),
    .reset_in       (reset),
    .reg_addr_in    (reg_addr),
    .reg_wr_in      (reg_wr),
    .reg_rd_in      (reg_rd),
    .reg_wdata_in   (reg_wdata),
    .reg_rdata_out  (reg_rdata),
    .acc_in         (acc),
    .mapped_acc_out (mapped),
    .any_motion_out (any_m),
    .no_motion_out  (no_m),
    .int1_out       (int1)
  );

  mfc_host_model u_host (
    .core_clk_in   (core_clk),
    .reg_addr_out  (reg_addr),
    .reg_wr_out    (reg_wr),
    .reg_rd_out    (reg_rd),
    .reg_wdata_out (reg_wdata),
    .reg_rdata_in  (reg_rdata)
  );

  // ***************************
  // Helpers
  // ***************************
  function automatic mfc_axes_t exp_map(input logic [8:0] r, input mfc_axes_t a);
    mfc_axes_t  o;
    logic [1:0] c;
    for (int i = 0; i < 3; i++) begin
      c = r[3*i +: 2];
      o.axis[i] = a.axis[(c == 2'h3) ? i : c];
      if (r[3*i+2]) begin
        o.axis[i] = -o.axis[i];
      end
    end
    return o;
  endfunction

  // Wide enough for a whole sample plus the status bits beside it
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (bad_count == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Touching another register rewinds the pointer, then reads skip ahead
  task automatic set_word(input int ofs, input logic [15:0] w);
    u_host.xfer(`MFC_MAP1_ADDR, 1'b0, 8'h00, rb);
    repeat (ofs) u_host.xfer(`MFC_PORT_ADDR, 1'b0, 8'h00, rb);
    u_host.xfer(`MFC_PORT_ADDR, 1'b1, w[7:0], rb);
    u_host.xfer(`MFC_PORT_ADDR, 1'b1, w[15:8], rb);
    u_host.idle();
  endtask

  task automatic set_map(input logic [7:0] v);
    u_host.xfer(`MFC_MAP1_ADDR, 1'b1, v, rb);
    u_host.idle();
  endtask

  // Step one axis, then follow the routed sample to find the tick
  task automatic hit(input int k);
    mfc_axes_t m;
    int        n;
    acc.axis[k] = acc.axis[k] ^ 16'h1000;
    m = mapped;
    n = 0;
    while (mapped === m && n < 2 * SC) begin
      @(negedge core_clk);
      n++;
    end
    chk(n < 2 * SC, 1'b1);
    repeat (2) @(negedge core_clk);
  endtask

  // ***************************
  // Clock, watchdog and tests
  // ***************************
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  initial begin
    repeat (20000) @(negedge core_clk);
    bad_count++;
    tally_and_finish();
  end

  initial begin
    reset = 1'b1;
    acc   = 48'h0300_0200_0100;
    repeat (8) @(negedge core_clk);
    reset = 1'b0;
    for (int i = 0; i < 12; i++) u_host.xfer(`MFC_PORT_ADDR, 1'b1, rows[i].wdata, rb);
    u_host.xfer(`MFC_MAP1_ADDR, 1'b0, 8'h00, rb);
    chk(rb, 8'h00);
    for (int i = 0; i < 12; i++) begin
      u_host.xfer(`MFC_PORT_ADDR, 1'b0, 8'h00, rb);
      chk(rb, rows[i].after);
    end
    u_host.idle();
    foreach (remaps[i]) begin
      set_word(10, {7'h00, remaps[i]});
      repeat (2 * SC + 2) @(negedge core_clk);
      chk(mapped, exp_map(remaps[i], acc));
    end
    // Detectors: x only, threshold 0x10, three samples
    set_word(10, 16'h0088);
    set_word(6, 16'h0000);
    set_word(0, 16'h0010);
    set_word(2, 16'h2003);
    set_map(8'h20);
    repeat (4) hit(1);
    chk(any_m, 1'b0);
    hit(0);
    hit(0);
    chk(any_m, 1'b0);
    hit(0);
    chk({any_m, int1}, 2'h3);
    set_map(8'h00);
    hit(0);
    chk({any_m, int1}, 2'h2);
    set_word(6, 16'h2000);
    set_map(8'h40);
    repeat (3 * SC) @(negedge core_clk);
    chk({no_m, any_m, int1}, 3'h5);
    // Reset in mid-run brings the defaults back
    reset = 1'b1;
    repeat (2) @(negedge core_clk);
    chk({reg_rdata, int1, any_m, no_m, mapped}, 59'h0);
    reset = 1'b0;
    for (int i = 0; i < 12; i++) begin
      u_host.xfer(`MFC_PORT_ADDR, 1'b0, 8'h00, rb);
      chk(rb, rows[i].rst);
    end
    u_host.idle();
    tally_and_finish();
  end
endmodule
